// ===== inc/cmpb_pkg.sv
// ==========================================================
// comparator bus, sync and approximation constants
package cmpb_pkg;
    // ==========================================================
    // widths
    localparam int COLS = 4;
    localparam int IO_AW = 8;
    localparam int IO_DW = 8;
    localparam int AV_AW = 2;
    localparam int AV_DW = 32;

    // ==========================================================
    // device io map
    localparam logic [7:0] ADDR_CMP_STATE_IRQ_SEL = 8'h64; // comparator_state_and_irq_select
    localparam logic [7:0] ADDR_SYNC_SAR_CTRL = 8'h65;     // sync_and_sar_control
    localparam logic [7:0] ADDR_SC_LO = 8'h80;             // first switched-capacitor register
    localparam logic [7:0] ADDR_SC_HI = 8'h9f;             // last switched-capacitor register
    localparam logic [7:0] ADDR_DAC_VALUE = 8'h90;         // dac_value_register, in sc space
    localparam logic [7:0] RST_REG = 8'h00;

    // comparator_state_and_irq_select fields
    localparam int CMP_STATE_LSB = 4;
    localparam int IRQ_SEL_LSB = 0;
    // sync_and_sar_control fields
    localparam int WSTALL_EN_BIT = 0;
    localparam int COLSEL_LSB = 1;
    localparam int POLARITY_BIT = 3;
    localparam int COUNT_LSB = 4;
    localparam int COUNT_W = 3;
    localparam logic [7:0] SYNC_CTRL_WMASK = 8'h7f; // bit 7 reserved, reads zero

    // irq source select encodings
    localparam logic IRQ_SRC_CMP_BUS = 1'b0;
    localparam logic IRQ_SRC_PHASE2_FALL = 1'b1;

    // ==========================================================
    // host avalon register map (word index)
    localparam logic [1:0] HR_IO_ADDR = 2'h0;
    localparam logic [1:0] HR_IO_DATA = 2'h1;
    localparam logic [1:0] HR_IO_OR = 2'h2;
    localparam logic [1:0] HR_STATUS = 2'h3;
    localparam int HS_STALL_BIT = 0;
    localparam int HS_RDATA_LSB = 8;

    typedef enum logic [1:0] {
        HST_IDLE = 2'b00,
        HST_STRB = 2'b01,
        HST_WAIT = 2'b10,
        HST_ACK = 2'b11
    } cmpb_hstate_t;
endpackage

// ===== inc/cmpb_if.sv
`timescale 1ns/100ps
// ==========================================================
// cpu io port between the controller and the analog digital logic
interface cmpb_if;
    logic [7:0] io_addr;
    logic [7:0] io_wdata;
    logic io_wr;    // one-cycle write strobe
    logic io_rd;    // one-cycle read strobe
    logic io_rmw;   // write half of a read-modify-write or
    logic [7:0] io_rdata;
    logic io_stall; // cpu held while high

    modport host (output io_addr, output io_wdata, output io_wr, output io_rd,
                  output io_rmw, input io_rdata, input io_stall);
    modport dev (input io_addr, input io_wdata, input io_wr, input io_rd,
                 input io_rmw, output io_rdata, output io_stall);
endinterface

// ===== design/cmpb_dev.sv
// Local design decision: the Avalon-MM register port.
`timescale 1ns/100ps
// Functional notes
// - one enabled comparator per column bus
// - column latch follows bus while phase two high
// - phase two low holds value from falling edge
// - only latched value feeds digital and status
// - ct blocks: enable and phase choose latching
// - sc blocks always latch, phase selectable
// - status bits 7:4 ro, irq selects 3:0 rw
// - select 0 bus, 1 phase two fall interrupts
// - sc write stalls cpu until phase one rise
// - stalling persists until enable bit cleared
// - software updates sc at phase one start
// - firmware loads control, sets sign guess first
// - or write: test guess, set next lower
// - six ors finish six bits, read result
// - bits 6:4 hold initial bit count
// - bit 3 inverts comparator polarity
// - bits 2:1 select comparator column
// - column clock not power-of-two above cpu
// - faster cpu safe, non power-of-two safe
module cmpb_dev (
    input wire logic clk,
    input wire logic rst,
    cmpb_if.dev io,
    input wire logic analog_phase_one_clock,
    input wire logic analog_phase_two_clock,
    input wire logic [cmpb_pkg::COLS-1:0] comp_bus,
    input wire logic [cmpb_pkg::COLS-1:0] column_is_sc,
    input wire logic [cmpb_pkg::COLS-1:0] ct_latch_enable,
    input wire logic [cmpb_pkg::COLS-1:0] ct_latch_phase_select,
    input wire logic [cmpb_pkg::COLS-1:0] sc_latch_phase_select,
    output logic [cmpb_pkg::COLS-1:0] comp_to_digital,
    output logic [cmpb_pkg::COLS-1:0] column_irq,
    output logic [7:0] dac_value
);
    import cmpb_pkg::*;

    // ==========================================================
    // state
    logic analog_phase_one_clock_q_r;
    logic analog_phase_two_clock_q_r;
    logic [COLS-1:0] blk_lat_r;
    logic [COLS-1:0] col_lat_r;
    logic [COLS-1:0] col_lat_q_r;
    logic [COLS-1:0] irq_r;
    logic [COLS-1:0] irq_nxt;
    logic [7:0] cmp_reg_r;
    logic [7:0] sync_reg_r;
    logic [7:0] sync_reg_nxt;
    logic [7:0] dac_r;
    logic [7:0] dac_nxt;
    logic [7:0] rdata_r;
    logic stall_r;
    logic [7:0] pend_addr_r;
    logic [7:0] pend_data_r;
    logic pend_rmw_r;

    // ==========================================================
    // phase edges; phase clocks arrive synchronous to clk
    wire analog_phase_one_clock_rise = analog_phase_one_clock & ~analog_phase_one_clock_q_r;
    wire analog_phase_two_clock_fall = ~analog_phase_two_clock & analog_phase_two_clock_q_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            analog_phase_one_clock_q_r <= 1'b0;
            analog_phase_two_clock_q_r <= 1'b0;
        end else begin
            analog_phase_one_clock_q_r <= analog_phase_one_clock;
            analog_phase_two_clock_q_r <= analog_phase_two_clock;
        end
    end

    // ==========================================================
    // per-column latching; the bus itself carries one driver only
    genvar c;
    generate
        for (c = 0; c < COLS; c++) begin : g_col
            // sc blocks always latch, ct blocks only when enabled
            wire use_blk = column_is_sc[c] | ct_latch_enable[c];
            wire blk_phase = column_is_sc[c] ? sc_latch_phase_select[c]
                                             : ct_latch_phase_select[c];
            // phase select 1 latches on phase two, 0 on phase one
            wire blk_open = blk_phase ? analog_phase_two_clock : analog_phase_one_clock;
            wire blk_out = use_blk ? blk_lat_r[c] : comp_bus[c];

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    blk_lat_r[c] <= 1'b0;
                    col_lat_r[c] <= 1'b0;
                end else begin
                    if (blk_open) begin
                        blk_lat_r[c] <= comp_bus[c];
                    end
                    // tracks while phase two high, else holds the last sample
                    if (analog_phase_two_clock) begin
                        col_lat_r[c] <= blk_out;
                    end
                end
            end

            // bus source fires on a rising latched comparator
            assign irq_nxt[c] = (cmp_reg_r[IRQ_SEL_LSB + c] == IRQ_SRC_PHASE2_FALL)
                                ? analog_phase_two_clock_fall
                                : (col_lat_r[c] & ~col_lat_q_r[c]);
        end
    endgenerate

    // ==========================================================
    // write path: a stalled sc write is applied at the phase one rise
    wire wr_is_sc = (io.io_addr >= ADDR_SC_LO) && (io.io_addr <= ADDR_SC_HI);
    // the enable bit is level-checked on every write, so the mode persists
    wire wr_stalls = io.io_wr && wr_is_sc && sync_reg_r[WSTALL_EN_BIT];
    wire release_now = stall_r && analog_phase_one_clock_rise;
    wire app_wr = (io.io_wr && !wr_stalls && !stall_r) || release_now;
    wire [7:0] app_addr = release_now ? pend_addr_r : io.io_addr;
    wire [7:0] app_data = release_now ? pend_data_r : io.io_wdata;
    wire app_rmw = release_now ? pend_rmw_r : io.io_rmw;

    // ==========================================================
    // approximation accelerator decode
    wire [COUNT_W-1:0] bit_count = sync_reg_r[COUNT_LSB +: COUNT_W];
    wire [1:0] col_sel = sync_reg_r[COLSEL_LSB +: 2];
    wire polarity = sync_reg_r[POLARITY_BIT];
    // latched column value only, never the raw bus
    wire cmp_sample = col_lat_r[col_sel] ^ polarity;
    wire [COUNT_W-1:0] guess_idx = bit_count - 3'h1;
    wire [7:0] guess_mask = 8'h01 << guess_idx;
    wire [7:0] next_mask = guess_mask >> 1;
    // keep the guess when the comparator says the input is above it
    wire [7:0] sar_dac = (dac_r & ~guess_mask) | (cmp_sample ? guess_mask : 8'h00) | next_mask;
    wire sar_step = app_wr && app_rmw && (app_addr == ADDR_DAC_VALUE)
                    && (bit_count != 3'h0);
    wire wr_dac = app_wr && (app_addr == ADDR_DAC_VALUE);
    wire wr_cmp = app_wr && (app_addr == ADDR_CMP_STATE_IRQ_SEL);
    wire wr_sync = app_wr && (app_addr == ADDR_SYNC_SAR_CTRL);

    // dac update: accelerator owns the or write while counting
    always_comb begin
        dac_nxt = dac_r;
        if (sar_step) begin
            dac_nxt = sar_dac;
        end else if (wr_dac) begin
            dac_nxt = app_data;
        end
    end

    // control update; the count falls by one per qualifying or
    always_comb begin
        sync_reg_nxt = sync_reg_r;
        if (wr_sync) begin
            sync_reg_nxt = app_data & SYNC_CTRL_WMASK;
        end else if (sar_step) begin
            sync_reg_nxt[COUNT_LSB +: COUNT_W] = guess_idx;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmp_reg_r <= RST_REG;
            sync_reg_r <= RST_REG;
            dac_r <= RST_REG;
        end else begin
            if (wr_cmp) begin
                cmp_reg_r[IRQ_SEL_LSB +: COLS] <= app_data[IRQ_SEL_LSB +: COLS];
            end
            cmp_reg_r[CMP_STATE_LSB +: COLS] <= col_lat_r;
            sync_reg_r <= sync_reg_nxt;
            dac_r <= dac_nxt;
        end
    end

    // ==========================================================
    // stall and pending write; cpu waits for the next phase one rise
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stall_r <= 1'b0;
            pend_addr_r <= RST_REG;
            pend_data_r <= RST_REG;
            pend_rmw_r <= 1'b0;
        end else if (wr_stalls && !stall_r) begin
            stall_r <= 1'b1;
            pend_addr_r <= io.io_addr;
            pend_data_r <= io.io_wdata;
            pend_rmw_r <= io.io_rmw;
        end else if (release_now) begin
            stall_r <= 1'b0;
        end
    end

    // ==========================================================
    // read data and outputs; reserved bit 7 of control reads zero
    wire [7:0] rd_mux = (io.io_addr == ADDR_CMP_STATE_IRQ_SEL) ? cmp_reg_r :
                        (io.io_addr == ADDR_SYNC_SAR_CTRL) ? sync_reg_r :
                        (io.io_addr == ADDR_DAC_VALUE) ? dac_r : 8'h00;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= RST_REG;
            col_lat_q_r <= '0;
            irq_r <= '0;
            comp_to_digital <= '0;
        end else begin
            if (io.io_rd) begin
                rdata_r <= rd_mux;
            end
            col_lat_q_r <= col_lat_r;
            irq_r <= irq_nxt;
            comp_to_digital <= col_lat_r;
        end
    end

    // software pacing and clock ratios are the far side's duty
    assign io.io_rdata = rdata_r;
    assign io.io_stall = stall_r;
    assign column_irq = irq_r;
    assign dac_value = dac_r;
endmodule // cmpb_dev

// ===== design/cmpb_host.sv
`timescale 1ns/100ps
// cpu-side controller: avalon-mm slave toward software, io master toward the device
module cmpb_host (
    input wire logic clk,
    input wire logic rst,
    cmpb_if.host io,
    input wire logic [cmpb_pkg::AV_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [cmpb_pkg::AV_DW-1:0] avs_writedata,
    output logic [cmpb_pkg::AV_DW-1:0] avs_readdata,
    output logic avs_waitrequest
);
    import cmpb_pkg::*;

    // ==========================================================
    // state
    cmpb_hstate_t st_r;
    logic wait_r;
    logic [AV_DW-1:0] rdata_r;
    logic [7:0] addr_r;
    logic [7:0] wdata_r;
    logic [7:0] opnd_r;
    logic [7:0] last_rd_r;
    logic wr_r;
    logic rd_r;
    logic rmw_r;
    logic is_or_r;
    logic is_rd_r;
    logic stall_seen_r;

    // ==========================================================
    // request decode
    wire take = (st_r == HST_IDLE) && wait_r && (avs_read || avs_write);
    wire io_op_rd = avs_read && (avs_address == HR_IO_DATA);
    wire io_op_wr = avs_write && (avs_address == HR_IO_DATA);
    wire io_op_or = avs_write && (avs_address == HR_IO_OR);
    wire io_op = io_op_rd || io_op_wr || io_op_or;
    wire [AV_DW-1:0] local_rd = (avs_address == HR_IO_ADDR) ? {24'h0, addr_r} :
                                (avs_address == HR_STATUS)
                                ? {16'h0, last_rd_r, 7'h0, stall_seen_r} : '0;

    // sequencer; an or is a read strobe then a write strobe with rmw
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= HST_IDLE;
            wait_r <= 1'b1;
            rdata_r <= '0;
            addr_r <= RST_REG;
            wdata_r <= RST_REG;
            opnd_r <= RST_REG;
            last_rd_r <= RST_REG;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            rmw_r <= 1'b0;
            is_or_r <= 1'b0;
            is_rd_r <= 1'b0;
            stall_seen_r <= 1'b0;
        end else begin
            unique case (st_r)
                HST_IDLE: begin
                    if (take && io_op) begin
                        is_or_r <= io_op_or;
                        is_rd_r <= io_op_rd;
                        rd_r <= io_op_rd || io_op_or;
                        wr_r <= io_op_wr;
                        rmw_r <= 1'b0;
                        wdata_r <= avs_writedata[7:0];
                        opnd_r <= avs_writedata[7:0];
                        st_r <= HST_STRB;
                    end else if (take) begin
                        if (avs_write && avs_address == HR_IO_ADDR) begin
                            addr_r <= avs_writedata[7:0];
                        end
                        if (avs_read) begin
                            rdata_r <= local_rd;
                        end
                        wait_r <= 1'b0;
                        st_r <= HST_ACK;
                    end
                end
                HST_STRB: begin
                    rd_r <= 1'b0;
                    wr_r <= 1'b0;
                    // rmw marks only the cycle of its own write strobe
                    rmw_r <= 1'b0;
                    st_r <= HST_WAIT;
                end
                HST_WAIT: begin
                    // a stalled write holds the bus request open
                    if (io.io_stall) begin
                        stall_seen_r <= 1'b1;
                    end else if (is_or_r) begin
                        wdata_r <= io.io_rdata | opnd_r;
                        wr_r <= 1'b1;
                        rmw_r <= 1'b1;
                        is_or_r <= 1'b0; // read half done, next wait ends the or
                        st_r <= HST_STRB;
                    end else begin
                        if (is_rd_r) begin
                            rdata_r <= {24'h0, io.io_rdata};
                            last_rd_r <= io.io_rdata;
                        end
                        rmw_r <= 1'b0;
                        wait_r <= 1'b0;
                        st_r <= HST_ACK;
                    end
                end
                HST_ACK: begin
                    wait_r <= 1'b1;
                    st_r <= HST_IDLE;
                end
            endcase
        end
    end

    assign io.io_addr = addr_r;
    assign io.io_wdata = wdata_r;
    assign io.io_wr = wr_r;
    assign io.io_rd = rd_r;
    assign io.io_rmw = rmw_r;
    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
endmodule // cmpb_host

// ===== verification/cmpb_checker.sv
`timescale 1ns/100ps
// ==========================================================
// io link checker between the controller and the device
module cmpb_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic analog_phase_one_clock,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic io_rmw,
    input wire logic [7:0] io_rdata,
    input wire logic io_stall
);
    import cmpb_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [6:0] ctrl_r;
    logic [3:0] sel_r;
    logic [3:0] low_cnt_r;
    wire sc_hit = (io_addr >= ADDR_SC_LO) && (io_addr <= ADDR_SC_HI);
    // shadow of the written control bits; the low count lets a slow sync chain settle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= 7'h00;
            sel_r <= 4'h0;
            low_cnt_r <= 4'h0;
        end else begin
            if (io_wr && io_addr == ADDR_SYNC_SAR_CTRL) ctrl_r <= io_wdata[6:0];
            if (io_wr && io_addr == ADDR_CMP_STATE_IRQ_SEL) sel_r <= io_wdata[3:0];
            if (analog_phase_one_clock) low_cnt_r <= 4'h0;
            else if (low_cnt_r != 4'hf) low_cnt_r <= low_cnt_r + 4'h1;
        end
    end
    stall_start_a: assert property (io_wr && sc_hit && ctrl_r[0] |=> io_stall)
        else $error("sc write with stall enabled did not stall");
    stall_none_a: assert property (io_wr && !(sc_hit && ctrl_r[0]) |=> !io_stall)
        else $error("stall raised without enabled sc write");
    stall_hold_a: assert property (io_stall && !analog_phase_one_clock && low_cnt_r >= 4'h4
        |=> io_stall)
        else $error("stall dropped without phase one rise");
    stall_release_a: assert property ($rose(analog_phase_one_clock) && io_stall
        |-> ##[1:4] !io_stall)
        else $error("stall not released after phase one rise");
    stall_quiet_a: assert property (io_stall |-> !io_wr && !io_rd)
        else $error("strobe issued while stalled");
    rmw_pair_a: assert property (io_rmw |-> io_wr && $past(io_rd, 2))
        else $error("or write without preceding read");
    ctrl_read_a: assert property (io_rd && io_addr == ADDR_SYNC_SAR_CTRL
        |=> io_rdata[3:0] == ctrl_r[3:0] && !io_rdata[7])
        else $error("control readback mismatch");
    sel_read_a: assert property (io_rd && io_addr == ADDR_CMP_STATE_IRQ_SEL
        |=> io_rdata[3:0] == sel_r)
        else $error("irq select readback mismatch");
    cover property (io_stall ##1 !io_stall);
    cover property (io_rmw);
    cover property (io_rd && io_addr == ADDR_CMP_STATE_IRQ_SEL);
endmodule // cmpb_checker

// ===== verification/comparator_bus_sar_sync_bench.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module comparator_bus_sar_sync_bench;
    import cmpb_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] avs_address = 2'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic analog_phase_one_clock = 1'b0;
    logic analog_phase_two_clock = 1'b0;
    logic [3:0] comp_bus = 4'h0; // one driving comparator per column bus
    logic [3:0] column_is_sc = 4'h0;
    logic [3:0] ct_latch_enable = 4'h0;
    logic [3:0] ct_latch_phase_select = 4'h0;
    logic [3:0] sc_latch_phase_select = 4'h0;
    logic [3:0] comp_to_digital;
    logic [3:0] column_irq;
    logic [7:0] dac_value;
    logic [4:0] ph_cnt = 5'h00;
    logic [7:0] rdq, exp_dac, tgt;
    logic [3:0] irq_seen;
    logic keep;
    int failures = 0;
    int compares = 0;
    int lat, lat0, cyc = 0;
    cmpb_if io_if();
    cmpb_host cmpb_host_i(.clk(clk), .rst(rst), .io(io_if), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    cmpb_dev cmpb_dev_i(.clk(clk), .rst(rst), .io(io_if),
        .analog_phase_one_clock(analog_phase_one_clock),
        .analog_phase_two_clock(analog_phase_two_clock), .comp_bus(comp_bus),
        .column_is_sc(column_is_sc), .ct_latch_enable(ct_latch_enable),
        .ct_latch_phase_select(ct_latch_phase_select),
        .sc_latch_phase_select(sc_latch_phase_select), .comp_to_digital(comp_to_digital),
        .column_irq(column_irq), .dac_value(dac_value));
    cmpb_checker cmpb_checker_i(.clk(clk), .rst(rst),
        .analog_phase_one_clock(analog_phase_one_clock), .io_addr(io_if.io_addr),
        .io_wdata(io_if.io_wdata), .io_wr(io_if.io_wr), .io_rd(io_if.io_rd),
        .io_rmw(io_if.io_rmw), .io_rdata(io_if.io_rdata), .io_stall(io_if.io_stall));
    // ==========================================================
    // clock, free phase one (32 cycles), hang guard
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        ph_cnt <= ph_cnt + 5'h01;
        analog_phase_one_clock <= ph_cnt[4]; // cpu clock faster than column clock
        cyc++;
        if (cyc == 30000) begin
            failures++;
            $display("ERROR timeout expected end seen hang");
            end_sim();
        end
    end
    task automatic end_sim();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // one avalon transfer; request held until waitrequest is sampled low
    task automatic av(input logic rd, input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_read <= rd;
        avs_write <= !rd;
        avs_writedata <= {24'h0, d};
        lat = 0;
        // no cycle count assumed; only the bench timeout ends a hung wait
        do begin
            @(posedge clk);
            lat++;
        end while (avs_waitrequest !== 1'b0);
        rdq = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic io_w(input logic [7:0] a, input logic [7:0] d);
        av(1'b0, HR_IO_ADDR, a);
        av(1'b0, HR_IO_DATA, d);
    endtask
    task automatic io_r(input logic [7:0] a);
        av(1'b0, HR_IO_ADDR, a);
        av(1'b1, HR_IO_DATA, 8'h00);
    endtask
    task automatic watch(input int n);
        irq_seen = 4'h0;
        repeat (n) begin
            @(posedge clk);
            irq_seen |= column_irq;
        end
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        io_r(ADDR_CMP_STATE_IRQ_SEL);
        `CHK("cmp reset", 8'h00, rdq);
        io_r(ADDR_SYNC_SAR_CTRL);
        `CHK("ctrl reset", 8'h00, rdq);
        io_w(ADDR_SYNC_SAR_CTRL, 8'hff);
        io_r(ADDR_SYNC_SAR_CTRL);
        `CHK("ctrl rw", 8'h7f, rdq);
        io_w(ADDR_SYNC_SAR_CTRL, 8'h00);
        // latch follows while phase two high, holds while low
        comp_bus <= 4'ha;
        analog_phase_two_clock <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("latch follow", 4'ha, comp_to_digital);
        analog_phase_two_clock <= 1'b0;
        repeat (2) @(posedge clk);
        comp_bus <= 4'h5;
        repeat (4) @(posedge clk);
        `CHK("latch hold", 4'ha, comp_to_digital);
        io_r(ADDR_CMP_STATE_IRQ_SEL);
        `CHK("cmp state", 4'ha, rdq[7:4]);
        analog_phase_two_clock <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("latch follow2", 4'h5, comp_to_digital);
        // irq source per column: phase two fall versus bus edge
        // bus held steady, so only phase-two selected columns may fire
        for (int i = 0; i < 3; i++) begin
            io_w(ADDR_CMP_STATE_IRQ_SEL, {4'h0, 4'hf >> (2 * i)} & 8'h0f);
            analog_phase_two_clock <= 1'b0;
            watch(6);
            `CHK("irq phase", 4'(4'hf >> (2 * i)), irq_seen);
            analog_phase_two_clock <= 1'b1;
            repeat (4) @(posedge clk);
        end
        comp_bus <= 4'ha;
        watch(6);
        `CHK("irq bus", 4'ha, irq_seen);
        // block latch on column 0: sc latch, then enabled ct latch; phase one
        for (int m = 0; m < 2; m++) begin
            column_is_sc <= m ? 4'h0 : 4'h1;
            ct_latch_enable <= m ? 4'h1 : 4'h0;
            comp_bus <= 4'h0;
            do @(posedge clk); while (analog_phase_one_clock !== 1'b0);
            do @(posedge clk); while (analog_phase_one_clock !== 1'b1);
            comp_bus <= 4'h1;
            repeat (4) @(posedge clk);
            `CHK("blk open", 1'b1, comp_to_digital[0]);
            do @(posedge clk); while (analog_phase_one_clock !== 1'b0);
            comp_bus <= 4'h0;
            repeat (4) @(posedge clk);
            `CHK("blk hold", 1'b1, comp_to_digital[0]);
        end
        column_is_sc <= 4'h0;
        ct_latch_enable <= 4'h0;
        // stalled sc writes land at phase one rise, until disabled
        io_w(ADDR_DAC_VALUE, 8'h11);
        lat0 = lat;
        io_w(ADDR_SYNC_SAR_CTRL, 8'h01);
        for (int k = 0; k < 2; k++) begin
            io_w(ADDR_DAC_VALUE, 8'h22 + 8'(k));
            `CHK("stalled", 1'b1, lat > lat0);
            `CHK("phase one", 1'b1, analog_phase_one_clock);
            `CHK("dac stalled", 8'h22 + 8'(k), dac_value);
        end
        io_w(ADDR_SYNC_SAR_CTRL, 8'h00);
        io_w(ADDR_DAC_VALUE, 8'h44);
        `CHK("unstalled", lat0, lat);
        // approximation runs: column 2 plain, column 1 inverted polarity
        for (int k = 0; k < 2; k++) begin
            tgt = k ? 8'h16 : 8'h2b;
            io_w(ADDR_SYNC_SAR_CTRL, {1'b0, 3'd6, k[0], k ? 2'd1 : 2'd2, 1'b0});
            io_w(ADDR_DAC_VALUE, 8'h20);
            exp_dac = 8'h20;
            for (int b = 6; b >= 1; b--) begin
                keep = exp_dac <= tgt;
                comp_bus <= (keep ^ k[0]) ? (4'h1 << (k ? 1 : 2)) : ~(4'h1 << (k ? 1 : 2));
                repeat (4) @(posedge clk);
                av(1'b0, HR_IO_OR, 8'h00);
                if (!keep) exp_dac[b - 1] = 1'b0;
                if (b >= 2) exp_dac[b - 2] = 1'b1;
                `CHK("sar step", exp_dac, dac_value);
            end
            io_r(ADDR_DAC_VALUE);
            `CHK("sar result", tgt, rdq);
            av(1'b0, HR_IO_OR, 8'h80);
            `CHK("sar done", tgt | 8'h80, dac_value);
        end
        end_sim();
    end
endmodule // comparator_bus_sar_sync_bench
